// ### core/mchp_consts.svh
/*
  Constants of the host port: word addresses, status word layout, reset values, timing counts.
  Assumes it is included by bare name from the package and the host port module.
*/
`ifndef MCHP_CONSTS_SVH
`define MCHP_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define MCHP_REF_CLK_HZ 250000000
`define MCHP_REF_CLK_NOMINAL_HZ 19660800
`define MCHP_PROC_CYCLES 4
`define MCHP_RESET_MIN_CYCLES 8

// ----------------------------------------------------------------------
// host bus styles, {host_style_sel_hi, host_style_sel_lo}
// ----------------------------------------------------------------------
`define MCHP_STYLE_RW_STROBE 2'h0
`define MCHP_STYLE_HIGH_WRITE 2'h1
`define MCHP_STYLE_READY 2'h2
`define MCHP_STYLE_BYTE 2'h3

// ----------------------------------------------------------------------
// word addresses, taken from addr[4:1]
// ----------------------------------------------------------------------
`define MCHP_WADDR_CMD_STATUS 4'h0
`define MCHP_WADDR_ERROR_CAUSE 4'h1
`define MCHP_WADDR_EVENT_CAUSE 4'h2
`define MCHP_WADDR_INT_MASK 4'h3

// ----------------------------------------------------------------------
// main status word bits
// ----------------------------------------------------------------------
`define MCHP_MSW_INT_BIT 0
`define MCHP_MSW_BUSY_BIT 1
`define MCHP_MSW_ERR_BIT 2
`define MCHP_MSW_EVT_BIT 3
`define MCHP_MSW_STYLE_LSB 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MCHP_INT_MASK_RST 16'h0000
`define MCHP_CMD_CODE_RST 16'h0000

`endif

// ### core/mchp_host_port.sv
/*
  Parallel host port of a motion controller: strobe decode for four bus styles, command pacing,
  cause registers with masked interrupt request.
  Assumes all host pins are synchronous to ref_clk and the data pins are resolved outside.
*/
`timescale 1ns/1ps

`include "mchp_consts.svh"

// Operation
// - All timing is counted in cycles of the single reference clock.
// - Two strap inputs pick one of four bus styles that give the strobes and A0 their roles; wait behaves the same in all four.
// - Strobes are accepted only while cs_n is low and ignored while it is high.
// - int_n goes low on an enabled cause and is released when the cause words are read.
// - The present interrupt request level is a bit of the main status word.
// - A mask lets software keep int_n from being asserted.
// - Each command takes 4 clock cycles during which wait_request_n is low.
// - cmd_busy_n goes low on a taken write and high when its processing finishes.
// - A 16-bit bus uses all sixteen data lines, low byte on the low eight.
module mchp_host_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic host_style_sel_lo,
  input wire logic host_style_sel_hi,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [4:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe,
  input wire logic [7:0] error_event,
  input wire logic [7:0] event_event,
  output logic int_n,
  output logic wait_request_n,
  output logic cmd_busy_n,
  output logic cmd_valid,
  output logic [15:0] cmd_code
);
  import mchp_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mchp_state_t state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  mchp_style_t style_reg, style_next;
  logic wait_n_reg, wait_n_next;
  logic busy_n_reg, busy_n_next;
  logic int_n_reg, int_n_next;
  logic [7:0] err_reg, err_next;
  logic [7:0] evt_reg, evt_next;
  logic [15:0] mask_reg, mask_next;
  logic [15:0] dout_reg, dout_next;
  logic [1:0] oe_reg, oe_next;
  logic cmd_valid_reg, cmd_valid_next;
  logic [15:0] cmd_code_reg, cmd_code_next;

  logic rd_req, wr_req, byte_mode, take_rd, take_wr;
  logic [3:0] waddr;
  logic [15:0] status_word;

  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] din,
                                        input logic bmode, input logic a0);
    logic [15:0] res;
    res = din;
    if (bmode)
    begin
      res = a0 ? {din[7:0], cur[7:0]} : {cur[15:8], din[7:0]};
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------------
  // strobe decode per bus style
  // ----------------------------------------------------------------------
  always_comb
  begin
    byte_mode = (style_reg == `MCHP_STYLE_BYTE);
    waddr = addr[4:1];
    case (style_reg)
      `MCHP_STYLE_RW_STROBE:
      begin
        // rd_n carries read-not-write, wr_n is the data strobe
        rd_req = !wr_n && rd_n;
        wr_req = !wr_n && !rd_n;
      end
      default:
      begin
        rd_req = !rd_n && wr_n;
        wr_req = !wr_n && rd_n;
      end
    endcase
    take_rd = !cs_n && rd_req && (state_reg == MCHP_IDLE);
    take_wr = !cs_n && wr_req && (state_reg == MCHP_IDLE);
    status_word = 16'h0000;
    status_word[`MCHP_MSW_INT_BIT] = !int_n_reg;
    status_word[`MCHP_MSW_BUSY_BIT] = !busy_n_reg;
    status_word[`MCHP_MSW_ERR_BIT] = |err_reg;
    status_word[`MCHP_MSW_EVT_BIT] = |evt_reg;
    status_word[`MCHP_MSW_STYLE_LSB +: 2] = style_reg;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    style_next = style_reg;
    wait_n_next = wait_n_reg;
    busy_n_next = busy_n_reg;
    mask_next = mask_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    cmd_valid_next = 1'b0;
    cmd_code_next = cmd_code_reg;
    case (state_reg)
      MCHP_IDLE:
      begin
        if (take_rd || take_wr)
        begin
          state_next = MCHP_PROC;
          cnt_next = 2'h0;
          wait_n_next = 1'b0;
          busy_n_next = !take_wr;
        end
        if (take_rd)
        begin
          case (waddr)
            `MCHP_WADDR_CMD_STATUS: dout_next = status_word;
            `MCHP_WADDR_ERROR_CAUSE: dout_next = {8'h00, err_reg};
            `MCHP_WADDR_EVENT_CAUSE: dout_next = {8'h00, evt_reg};
            `MCHP_WADDR_INT_MASK: dout_next = mask_reg;
            default: dout_next = 16'h0000;
          endcase
          if (byte_mode && addr[0])
          begin
            dout_next = {8'h00, dout_next[15:8]};
          end
          oe_next = byte_mode ? 2'h1 : 2'h3;
        end
        if (take_wr)
        begin
          case (waddr)
            `MCHP_WADDR_CMD_STATUS:
            begin
              cmd_code_next = merge(cmd_code_reg, data_in, byte_mode, addr[0]);
              cmd_valid_next = !byte_mode || addr[0];
            end
            `MCHP_WADDR_INT_MASK: mask_next = merge(mask_reg, data_in, byte_mode, addr[0]);
            default: mask_next = mask_reg;
          endcase
        end
      end
      MCHP_PROC:
      begin
        cnt_next = cnt_reg + 2'h1;
        if (cnt_reg == 2'(`MCHP_PROC_CYCLES - 1))
        begin
          state_next = MCHP_HOLD;
          wait_n_next = 1'b1;
          busy_n_next = 1'b1;
        end
      end
      MCHP_HOLD:
      begin
        // the strobe must drop or cs_n rise before the next access is taken
        if (cs_n || !(rd_req || wr_req))
        begin
          state_next = MCHP_IDLE;
          oe_next = 2'h0;
        end
      end
      default: state_next = MCHP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // cause registers and interrupt request, a new event wins over the read clear
  // ----------------------------------------------------------------------
  always_comb
  begin
    err_next = err_reg;
    evt_next = evt_reg;
    if (take_rd && waddr == `MCHP_WADDR_ERROR_CAUSE)
    begin
      err_next = 8'h00;
    end
    if (take_rd && waddr == `MCHP_WADDR_EVENT_CAUSE)
    begin
      evt_next = 8'h00;
    end
    err_next = err_next | error_event;
    evt_next = evt_next | event_event;
    int_n_next = !(|((err_reg & mask_reg[7:0]) | (evt_reg & mask_reg[15:8])));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= MCHP_IDLE;
      cnt_reg <= 2'h0;
      style_reg <= {host_style_sel_hi, host_style_sel_lo};
      wait_n_reg <= 1'b1;
      busy_n_reg <= 1'b1;
      int_n_reg <= 1'b1;
      err_reg <= 8'h00;
      evt_reg <= 8'h00;
      mask_reg <= `MCHP_INT_MASK_RST;
      dout_reg <= 16'h0000;
      oe_reg <= 2'h0;
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= `MCHP_CMD_CODE_RST;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      style_reg <= style_next;
      wait_n_reg <= wait_n_next;
      busy_n_reg <= busy_n_next;
      int_n_reg <= int_n_next;
      err_reg <= err_next;
      evt_reg <= evt_next;
      mask_reg <= mask_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_code_reg <= cmd_code_next;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign int_n = int_n_reg;
  assign wait_request_n = wait_n_reg;
  assign cmd_busy_n = busy_n_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_code = cmd_code_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_proc;
    !wait_request_n [*4] ##1 wait_request_n;
  endsequence

  sequence s_busy;
    !cmd_busy_n [*4] ##1 cmd_busy_n;
  endsequence

  AST_WAIT_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take_rd || take_wr) |=> s_proc)
    else $error("wait request not low for exactly four cycles");

  AST_BUSY_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_wr |=> s_busy)
    else $error("busy not low for the write processing interval");

  AST_BUSY_RD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_rd |=> cmd_busy_n [*5])
    else $error("busy asserted on a read");

  AST_CS_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cs_n && state_reg == MCHP_IDLE) |=> wait_request_n && !cmd_valid)
    else $error("access taken while chip select high");

  AST_INT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(err_reg & mask_reg[7:0])) |=> !int_n)
    else $error("enabled error cause did not raise interrupt");

  AST_INT_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((err_reg & mask_reg[7:0]) == 8'h00 && (evt_reg & mask_reg[15:8]) == 8'h00) |=> int_n)
    else $error("interrupt asserted without an enabled cause");

  AST_ERR_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take_rd && waddr == `MCHP_WADDR_ERROR_CAUSE && error_event == 8'h00) |=> err_reg == 8'h00)
    else $error("error cause not cleared by its read");

  AST_MSW_INT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take_rd && waddr == `MCHP_WADDR_CMD_STATUS && !byte_mode) |=>
      data_out[`MCHP_MSW_INT_BIT] == !$past(int_n_reg))
    else $error("status word does not show interrupt level");

  AST_LANES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take_rd |=> data_oe == ($past(byte_mode) ? 2'h1 : 2'h3))
    else $error("wrong data lanes driven for bus style");

  AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take_wr && waddr == `MCHP_WADDR_INT_MASK && !byte_mode) |=> mask_reg == $past(data_in))
    else $error("mask write not decoded");
endmodule : mchp_host_port

// ### core/mchp_pkg.sv
/*
  Types of the host port.
  Assumes the constants header sits beside it.
*/
package mchp_pkg;
  `include "mchp_consts.svh"

  typedef enum logic [1:0] {
    MCHP_IDLE,
    MCHP_PROC,
    MCHP_HOLD
  } mchp_state_t;

  typedef logic [1:0] mchp_style_t;
endpackage : mchp_pkg

// ### verification/mchp_host_model.sv
/*
  Host processor model for the host port: strobes per bus style, held until wait_request_n rises.
  Assumes one ref_clk shared with the port and the style given by the caller matching the straps.
*/
`timescale 1ns/1ps
`include "mchp_consts.svh"
module mchp_host_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [4:0] addr,
  output logic [15:0] data_in,
  input wire logic wait_request_n,
  input wire logic cmd_busy_n,
  input wire logic [15:0] data_out
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h00;
    data_in = 16'hA5A5;
  end

  // ----------------------------------------------------------------------
  // one access; counts cycles of wait and busy low
  // ----------------------------------------------------------------------
  task automatic access(input logic wr, input logic [3:0] wa, input logic [15:0] wd, input logic [1:0] style,
                        input logic a0, output logic [15:0] rdata, output int low, output int bl,
                        output logic ok);
    int i;
    ok = 1'b0;
    low = 0;
    bl = 0;
    rdata = 16'h0000;
    for (i = 0; i < 20 && cmd_busy_n !== 1'b1; i++) @(posedge ref_clk);
    // busy never released: leave ok low so the caller counts a timeout
    if (cmd_busy_n !== 1'b1) return;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    addr <= {wa, a0};
    if (wr) data_in <= wd;
    if (style == `MCHP_STYLE_RW_STROBE)
    begin
      // rd_n carries read-not-write, wr_n strobes both kinds
      wr_n <= 1'b0;
      rd_n <= !wr;
    end
    else if (wr)
      wr_n <= 1'b0;
    else
      rd_n <= 1'b0;
    for (i = 0; i < 20 && !ok; i++)
    begin
      @(posedge ref_clk);
      if (cmd_busy_n === 1'b0) bl++;
      if (wait_request_n === 1'b0) low++;
      else if (low > 0)
      begin
        ok = 1'b1;
        rdata = data_out;
      end
    end
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // released lines show the inverse of wd
    data_in <= ~wd;
  endtask : access

  // write strobe with the chip not selected
  task automatic stray(output int low);
    int i;
    low = 0;
    @(posedge ref_clk);
    wr_n <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      if (wait_request_n === 1'b0) low++;
    end
    wr_n <= 1'b1;
  endtask : stray
endmodule : mchp_host_model

// ### verification/tb.sv
/*
  Self-checking bench of the host port: commands, reads, chip select, interrupt mask and clear.
  Assumes the design and its constants header are compiled first.
*/
`timescale 1ns/1ps
`include "mchp_consts.svh"
module tb;
  import mchp_pkg::*;
  logic ref_clk, rst_n, sel_lo, sel_hi, cs_n, rd_n, wr_n, int_n, wait_request_n, cmd_busy_n, cmd_valid, ok;
  logic [4:0] addr;
  logic [15:0] data_in, data_out, cmd_code, rd;
  logic [1:0] data_oe;
  logic [7:0] error_event, event_event;
  int n_fail, samples_checked, low, bl;
  int n_valid = 0;
  logic byte_hi = 1'b0;

  mchp_host_port mchp_host_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .host_style_sel_lo(sel_lo),
    .host_style_sel_hi(sel_hi), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .error_event(error_event), .event_event(event_event),
    .int_n(int_n), .wait_request_n(wait_request_n), .cmd_busy_n(cmd_busy_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code));
  mchp_host_model mchp_host_model_i (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .wait_request_n(wait_request_n), .cmd_busy_n(cmd_busy_n),
    .data_out(data_out));

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : check

  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic xfer(input logic wr, input logic [3:0] wa, input logic [15:0] wd);
    mchp_host_model_i.access(wr, wa, wd, {sel_hi, sel_lo}, byte_hi, rd, low, bl, ok);
    check({15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1) results();
  endtask : xfer

  // reset with new straps; outputs checked once the first edge after release has passed
  task automatic rerun(input logic hi, input logic lo);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    sel_hi <= hi;
    sel_lo <= lo;
    repeat (`MCHP_RESET_MIN_CYCLES) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({12'h000, int_n, wait_request_n, cmd_busy_n, cmd_valid}, 16'h000E);
    check({14'h0000, data_oe}, 16'h0000);
  endtask : rerun

  task automatic pulse(input logic [7:0] err, input logic [7:0] evt);
    @(posedge ref_clk);
    error_event <= err;
    event_event <= evt;
    @(posedge ref_clk);
    error_event <= 8'h00;
    event_event <= 8'h00;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic sc_write;
    int v0;
    for (int k = 0; k < 2; k++)
    begin
      v0 = n_valid;
      xfer(1'b1, `MCHP_WADDR_CMD_STATUS, k ? 16'hFFFF : 16'hC35A);
      check(16'(low), 16'(`MCHP_PROC_CYCLES));
      check(16'(bl), 16'(`MCHP_PROC_CYCLES));
      check(16'(n_valid - v0), 16'h0001);
      check(cmd_code, k ? 16'hFFFF : 16'hC35A);
    end
  endtask : sc_write

  task automatic sc_read;
    xfer(1'b0, `MCHP_WADDR_CMD_STATUS, 16'h0000);
    check(16'(low), 16'(`MCHP_PROC_CYCLES));
    check(16'(bl), 16'h0000);
    check(rd & 16'h0031, 16'h0010);
    check({14'h0000, data_oe}, 16'h0003);
    repeat (3) @(posedge ref_clk);
    check({14'h0000, data_oe}, 16'h0000);
  endtask : sc_read

  task automatic sc_cs;
    int v0;
    v0 = n_valid;
    mchp_host_model_i.stray(low);
    check(16'(low), 16'h0000);
    check(16'(n_valid - v0), 16'h0000);
    check({15'h0000, cmd_busy_n}, 16'h0001);
  endtask : sc_cs

  task automatic sc_irq;
    pulse(8'h04, 8'h00);
    check({15'h0000, int_n}, 16'h0001);
    xfer(1'b0, `MCHP_WADDR_ERROR_CAUSE, 16'h0000);
    check(rd, 16'h0004);
    xfer(1'b1, `MCHP_WADDR_INT_MASK, 16'h0184);
    pulse(8'h80, 8'h00);
    check({15'h0000, int_n}, 16'h0000);
    xfer(1'b0, `MCHP_WADDR_CMD_STATUS, 16'h0000);
    check(rd & 16'h0001, 16'h0001);
    xfer(1'b0, `MCHP_WADDR_ERROR_CAUSE, 16'h0000);
    check(rd, 16'h0080);
    check({15'h0000, int_n}, 16'h0001);
    pulse(8'h00, 8'h01);
    check({15'h0000, int_n}, 16'h0000);
    xfer(1'b0, `MCHP_WADDR_EVENT_CAUSE, 16'h0000);
    check(rd, 16'h0001);
    check({15'h0000, int_n}, 16'h0001);
  endtask : sc_irq

  task automatic sc_style;
    int v0;
    rerun(1'b1, 1'b1);
    v0 = n_valid;
    byte_hi = 1'b0;
    xfer(1'b1, `MCHP_WADDR_CMD_STATUS, 16'h005A);
    check(16'(n_valid - v0), 16'h0000);
    byte_hi = 1'b1;
    xfer(1'b1, `MCHP_WADDR_CMD_STATUS, 16'h00C3);
    check(16'(n_valid - v0), 16'h0001);
    check(cmd_code, 16'hC35A);
    xfer(1'b1, `MCHP_WADDR_INT_MASK, 16'h0001);
    xfer(1'b0, `MCHP_WADDR_INT_MASK, 16'h0000);
    check(rd, 16'h0001);
    check({14'h0000, data_oe}, 16'h0001);
    byte_hi = 1'b0;
    xfer(1'b0, `MCHP_WADDR_CMD_STATUS, 16'h0000);
    check(rd & 16'h0031, 16'h0030);
    rerun(1'b0, 1'b0);
    xfer(1'b1, `MCHP_WADDR_CMD_STATUS, 16'h1234);
    check(cmd_code, 16'h1234);
    check(16'(bl), 16'(`MCHP_PROC_CYCLES));
    xfer(1'b0, `MCHP_WADDR_CMD_STATUS, 16'h0000);
    check(16'(bl), 16'h0000);
    check(rd & 16'h0031, 16'h0000);
  endtask : sc_style

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    sel_lo = 1'b1;
    sel_hi = 1'b0;
    error_event = 8'h00;
    event_event = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    rerun(1'b0, 1'b1);
    sc_write();
    sc_read();
    sc_cs();
    sc_irq();
    sc_style();
    results();
  end
endmodule : tb
